// ---- core/result_threshold_interrupt.sv ----
// Purpose: Result registers and threshold interrupt logic
// Assumes: Byte register port from an I2C target; measurement engines outside
// Notes:   Read data registered one cycle after the read strobe
//
// Overview of operation
// - Ambient result: high byte at 85h, low byte at 86h.
// - Ambient result bytes read-only; writes change nothing.
// - Biosensor result: high byte at 87h, low byte at 88h.
// - Biosensor result bytes read-only; writes change nothing.
// - Low threshold read/write at 8Ah (high byte) and 8Bh.
// - High threshold read/write at 8Ch (high byte) and 8Dh.
// - Self-timed ambient run keeps old control byte until it stops; thresholds apply at once.
// - Status flags stick until host writes one to that bit.
// - Interrupt pin low while any status flag is set.
`timescale 1ns/1ns
`default_nettype none
module result_threshold_interrupt (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output var  logic [7:0]  regRdata,
    // Measurement engines
    input  wire logic [15:0] ambResult,
    input  wire logic        ambValid,
    input  wire logic [15:0] bioResult,
    input  wire logic        bioValid,
    input  wire logic        ambSelfTimed,
    // Interrupt pin
    output var  logic        intOutN
);
    import rti_pkg::*;

    logic [15:0] ambRes_q, ambRes_d, bioRes_q, bioRes_d;
    logic [15:0] lowThr_q, lowThr_d, highThr_q, highThr_d;
    logic [7:0]  ctrl_q, ctrl_d, actCtrl_q, actCtrl_d;
    logic [3:0]  flags_q, flags_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        intN_q, intN_d;
    logic        selfRun_q;
    logic [3:0]  events, clearMask;

    thr_if thr ();

    thr_persist uPersist (
        .mclk (mclk),
        .rstn (rstn),
        .thr  (thr)
    );

    function automatic logic wrHit(input logic [7:0] a);
        wrHit = regWr && (regAddr == a);
    endfunction : wrHit

    // Host writes never reach result registers
    always_comb begin
        ambRes_d = ambValid ? ambResult : ambRes_q;
        bioRes_d = bioValid ? bioResult : bioRes_q;
    end

    always_comb begin
        lowThr_d  = lowThr_q;
        highThr_d = highThr_q;
        ctrl_d    = ctrl_q;
        if (wrHit(ADDR_LOW_HI))   lowThr_d[15:8]  = regWdata;
        if (wrHit(ADDR_LOW_LO))   lowThr_d[7:0]   = regWdata;
        if (wrHit(ADDR_HIGH_HI))  highThr_d[15:8] = regWdata;
        if (wrHit(ADDR_HIGH_LO))  highThr_d[7:0]  = regWdata;
        if (wrHit(ADDR_INT_CTRL)) ctrl_d          = regWdata & CTRL_WR_MASK;
        // Control byte frozen during a self-timed run, taken once it stops
        actCtrl_d = (ambSelfTimed && selfRun_q) ? actCtrl_q : ctrl_q;
    end

    // Threshold source and strobe follow the active control
    assign thr.sample   = actCtrl_q[BIT_THR_SEL] ? ambValid : bioValid;
    assign thr.value    = actCtrl_q[BIT_THR_SEL] ? ambResult : bioResult;
    assign thr.lowThr   = lowThr_q;
    assign thr.highThr  = highThr_q;
    assign thr.persCode = actCtrl_q[PERS_LSB +: 3];

    always_comb begin
        events            = 4'h0;
        events[FLAG_BIO]  = bioValid && actCtrl_q[BIT_BIO_EN];
        events[FLAG_AMB]  = ambValid && actCtrl_q[BIT_AMB_EN];
        events[FLAG_LOW]  = thr.lowFire && actCtrl_q[BIT_THR_EN];
        events[FLAG_HIGH] = thr.highFire && actCtrl_q[BIT_THR_EN];
        clearMask = wrHit(ADDR_INT_STAT) ? regWdata[3:0] : 4'h0;
        // Set wins over a clear in the same cycle
        flags_d = (flags_q & ~clearMask) | events;
        intN_d  = ~(|flags_d);
    end

    always_comb begin
        rdata_d = rdata_q;
        if (regRd) begin
            unique case (regAddr)
                ADDR_AMB_HI:   rdata_d = ambRes_q[15:8];
                ADDR_AMB_LO:   rdata_d = ambRes_q[7:0];
                ADDR_BIO_HI:   rdata_d = bioRes_q[15:8];
                ADDR_BIO_LO:   rdata_d = bioRes_q[7:0];
                ADDR_INT_CTRL: rdata_d = ctrl_q;
                ADDR_LOW_HI:   rdata_d = lowThr_q[15:8];
                ADDR_LOW_LO:   rdata_d = lowThr_q[7:0];
                ADDR_HIGH_HI:  rdata_d = highThr_q[15:8];
                ADDR_HIGH_LO:  rdata_d = highThr_q[7:0];
                ADDR_INT_STAT: rdata_d = {4'h0, flags_q};
                default:       rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ambRes_q  <= 16'h0000;
            bioRes_q  <= 16'h0000;
            lowThr_q  <= THR_RESET;
            highThr_q <= THR_RESET;
            ctrl_q    <= CTRL_RESET;
            actCtrl_q <= CTRL_RESET;
            selfRun_q <= 1'b0;
            flags_q   <= 4'h0;
            rdata_q   <= 8'h00;
            intN_q    <= 1'b1;
        end else begin
            ambRes_q  <= ambRes_d;
            bioRes_q  <= bioRes_d;
            lowThr_q  <= lowThr_d;
            highThr_q <= highThr_d;
            ctrl_q    <= ctrl_d;
            actCtrl_q <= actCtrl_d;
            selfRun_q <= ambSelfTimed;
            flags_q   <= flags_d;
            rdata_q   <= rdata_d;
            intN_q    <= intN_d;
        end
    end

    assign regRdata = rdata_q;
    assign intOutN  = intN_q;
endmodule : result_threshold_interrupt
`default_nettype wire

// ---- core/rti_pkg.sv ----
// Purpose: Constants for the result and threshold interrupt block
// Assumes: Byte-wide register port behind an I2C target front end
// Notes:   Offsets are device register addresses
package rti_pkg;
    localparam logic [7:0] ADDR_AMB_HI   = 8'h85;
    localparam logic [7:0] ADDR_AMB_LO   = 8'h86;
    localparam logic [7:0] ADDR_BIO_HI   = 8'h87;
    localparam logic [7:0] ADDR_BIO_LO   = 8'h88;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h89;
    localparam logic [7:0] ADDR_LOW_HI   = 8'h8a;
    localparam logic [7:0] ADDR_LOW_LO   = 8'h8b;
    localparam logic [7:0] ADDR_HIGH_HI  = 8'h8c;
    localparam logic [7:0] ADDR_HIGH_LO  = 8'h8d;
    localparam logic [7:0] ADDR_INT_STAT = 8'h8e;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    // Bit 4 of the control byte is unused and always reads 0
    localparam logic [7:0] CTRL_WR_MASK  = 8'hef;
    localparam logic [15:0] THR_RESET    = 16'h0000;
    localparam int BIT_BIO_EN  = 3;
    localparam int BIT_AMB_EN  = 2;
    localparam int BIT_THR_EN  = 1;
    localparam int BIT_THR_SEL = 0;
    localparam int PERS_LSB    = 5;
    localparam int FLAG_BIO    = 3;
    localparam int FLAG_AMB    = 2;
    localparam int FLAG_LOW    = 1;
    localparam int FLAG_HIGH   = 0;
endpackage : rti_pkg

// ---- core/thr_if.sv ----
// Purpose: Carrier between register file and threshold persistence counter
// Assumes: Single clock domain
// Notes:   Sample strobe accompanies the selected value
`timescale 1ns/1ns
`default_nettype none
interface thr_if;
    logic        sample;
    logic [15:0] value;
    logic [15:0] lowThr;
    logic [15:0] highThr;
    logic [2:0]  persCode;
    logic        lowFire;
    logic        highFire;
    modport ctrl (output sample, value, lowThr, highThr, persCode,
                  input lowFire, highFire);
    modport pers (input sample, value, lowThr, highThr, persCode,
                  output lowFire, highFire);
endinterface : thr_if
`default_nettype wire

// ---- core/thr_persist.sv ----
// Purpose: Counts consecutive out-of-window samples
// Assumes: One sample strobe per completed measurement
// Notes:   Fire pulses once per reached count, then count restarts
`timescale 1ns/1ns
`default_nettype none
module thr_persist (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // Threshold link
    thr_if.pers       thr
);
    import rti_pkg::*;

    logic [7:0] lowCnt_q, lowCnt_d, highCnt_q, highCnt_d;
    logic       lowFire_q, lowFire_d, highFire_q, highFire_d;
    logic [7:0] target;

    always_comb begin
        target     = 8'h01 << thr.persCode; // 1..128 samples
        lowCnt_d   = lowCnt_q;
        highCnt_d  = highCnt_q;
        lowFire_d  = 1'b0;
        highFire_d = 1'b0;
        if (thr.sample) begin
            // Any in-window sample breaks the run
            if (thr.value < thr.lowThr) begin
                if (lowCnt_q + 8'h01 >= target) begin
                    lowFire_d = 1'b1;
                    lowCnt_d  = 8'h00;
                end else begin
                    lowCnt_d = lowCnt_q + 8'h01;
                end
            end else begin
                lowCnt_d = 8'h00;
            end
            if (thr.value > thr.highThr) begin
                if (highCnt_q + 8'h01 >= target) begin
                    highFire_d = 1'b1;
                    highCnt_d  = 8'h00;
                end else begin
                    highCnt_d = highCnt_q + 8'h01;
                end
            end else begin
                highCnt_d = 8'h00;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lowCnt_q   <= 8'h00;
            highCnt_q  <= 8'h00;
            lowFire_q  <= 1'b0;
            highFire_q <= 1'b0;
        end else begin
            lowCnt_q   <= lowCnt_d;
            highCnt_q  <= highCnt_d;
            lowFire_q  <= lowFire_d;
            highFire_q <= highFire_d;
        end
    end

    assign thr.lowFire  = lowFire_q;
    assign thr.highFire = highFire_q;
endmodule : thr_persist
`default_nettype wire

// ---- testbench/rti_checker.sv ----
// Purpose: Port checks for result_threshold_interrupt
// Assumes: Results captured on valid pulses
// Notes:   Shadow copy ignores host writes
`timescale 1ns/1ns
`default_nettype none
module rti_checker (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    // Watched ports
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [7:0]  regRdata,
    input wire logic [15:0] ambResult,
    input wire logic        ambValid,
    input wire logic [15:0] bioResult,
    input wire logic        bioValid,
    input wire logic        intOutN
);
    logic [15:0] ambQ_q;
    logic [15:0] bioQ_q;
    logic        rdOk;
    logic        anyV;
    assign rdOk = regRd && !ambValid && !bioValid;
    assign anyV = ambValid || bioValid;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ambQ_q <= 16'h0000;
            bioQ_q <= 16'h0000;
        end else begin
            if (ambValid) ambQ_q <= ambResult;
            if (bioValid) bioQ_q <= bioResult;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_amb_hi: assert property (
        rdOk && regAddr == 8'h85 |=> regRdata == $past(ambQ_q[15:8]))
        else $error("ambient high byte read wrong");
    a_amb_lo: assert property (
        rdOk && regAddr == 8'h86 |=> regRdata == $past(ambQ_q[7:0]))
        else $error("ambient low byte read wrong");
    a_bio_hi: assert property (
        rdOk && regAddr == 8'h87 |=> regRdata == $past(bioQ_q[15:8]))
        else $error("bio high byte read wrong");
    a_bio_lo: assert property (
        rdOk && regAddr == 8'h88 |=> regRdata == $past(bioQ_q[7:0]))
        else $error("bio low byte read wrong");
    a_int_hold: assert property (
        !intOutN && !(regWr && regAddr == 8'h8e) |=> !intOutN)
        else $error("interrupt released without clear");
    a_int_cause: assert property (
        $fell(intOutN) |-> $past(anyV) || $past(anyV, 2) || $past(anyV, 3))
        else $error("interrupt without a sample");
    a_low_back: assert property (
        regWr && regAddr == 8'h8a ##1 regRd && regAddr == 8'h8a
        |=> regRdata == $past(regWdata, 2))
        else $error("low threshold readback wrong");
    a_high_back: assert property (
        regWr && regAddr == 8'h8d ##1 regRd && regAddr == 8'h8d
        |=> regRdata == $past(regWdata, 2))
        else $error("high threshold readback wrong");
    c_int: cover property (!intOutN);
    c_ctrl: cover property (regWr && regAddr == 8'h89);
    c_bio: cover property (rdOk && regAddr == 8'h88);
endmodule : rti_checker
bind result_threshold_interrupt rti_checker u_chk (.mclk, .rstn, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .ambResult, .ambValid,
    .bioResult, .bioValid, .intOutN);
`default_nettype wire

// ---- testbench/meas_model.sv ----
// Purpose: Measurement engine stand-in
// Assumes: One valid pulse per finished measurement
// Notes:   Data shows inverted value outside valid
`timescale 1ns/1ns
`default_nettype none
module meas_model (
    // Clock
    input  wire logic        mclk,
    // Results
    output var  logic [15:0] ambResult,
    output var  logic        ambValid,
    output var  logic [15:0] bioResult,
    output var  logic        bioValid
);
    initial begin
        {ambResult, ambValid, bioResult, bioValid} = '0;
    end
    // Caller is at a falling edge; waits out the flag latency
    task automatic send(input logic isAmb, input logic [15:0] v);
        if (isAmb) {ambResult, ambValid} = {v, 1'b1};
        else {bioResult, bioValid} = {v, 1'b1};
        @(negedge mclk);
        {ambValid, bioValid} = 2'b00;
        ambResult = ~ambResult;
        bioResult = ~bioResult;
        repeat (3) @(negedge mclk);
    endtask : send
endmodule : meas_model
`default_nettype wire

// ---- testbench/result_threshold_interrupt_tb.sv ----
// Purpose: Register level test of result_threshold_interrupt
// Assumes: Byte strobes driven at falling edges
// Notes:   Flags read after the sample latency
`timescale 1ns/1ns
`default_nettype none
module result_threshold_interrupt_tb;
    import rti_pkg::*;
    logic        mclk, rstn, regWr, regRd, ambSelfTimed, intOutN;
    logic [7:0]  regAddr, regWdata, regRdata;
    logic [15:0] ambResult, bioResult;
    logic        ambValid, bioValid;
    int          n_fail, checked, cyc;
    result_threshold_interrupt u_dut (.mclk, .rstn, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .ambResult, .ambValid, .bioResult,
        .bioValid, .ambSelfTimed, .intOutN);
    meas_model u_src (.mclk, .ambResult, .ambValid, .bioResult, .bioValid);
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic end_sim;
        if (n_fail == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Strobe stays up; the next call or idle drops it, never twice a step
    task automatic wr(input logic [7:0] a, d);
        {regAddr, regWdata, regWr, regRd} = {a, d, 2'b10};
        @(negedge mclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, e);
        {regAddr, regRd, regWr} = {a, 2'b10};
        @(negedge mclk);
        chk($sformatf("reg %h", a), e, regRdata);
    endtask : rd
    task automatic idle;
        {regWr, regRd} = 2'b00;
        @(negedge mclk);
    endtask : idle
    // Bus quiet before a sample, so no repeated status clear eats a flag
    task automatic meas(input logic isAmb, input logic [15:0] v);
        idle();
        u_src.send(isAmb, v);
    endtask : meas
    task automatic wrd(input logic [7:0] a, d);
        wr(a, d);
        rd(a, d);
    endtask : wrd
    task automatic pin(input logic e);
        chk("intOutN", {7'h00, e}, {7'h00, intOutN});
    endtask : pin
    // Hang guard, run needs about 120 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        {regAddr, regWdata, regWr, regRd, ambSelfTimed, rstn} = '0;
        repeat (10) @(negedge mclk);
        rstn = 1'b1;
        for (int a = 8'h85; a <= 8'h8f; a++) rd(8'(a), 8'h00);
        pin(1'b1);
        meas(1'b1, 16'h1234);
        meas(1'b0, 16'hABCD);
        for (int a = 8'h85; a <= 8'h88; a++) wr(8'(a), 8'hff);
        rd(ADDR_AMB_HI, 8'h12);
        rd(ADDR_AMB_LO, 8'h34);
        rd(ADDR_BIO_HI, 8'hab);
        rd(ADDR_BIO_LO, 8'hcd);
        wrd(ADDR_LOW_HI, 8'h10);
        wrd(ADDR_HIGH_LO, 8'h01);
        wrd(ADDR_HIGH_HI, 8'h20);
        wr(ADDR_INT_CTRL, 8'h1e);
        rd(ADDR_INT_CTRL, 8'h0e);
        meas(1'b0, 16'h1800);
        rd(ADDR_INT_STAT, 8'h08);
        pin(1'b0);
        wr(ADDR_INT_STAT, 8'h08);
        rd(ADDR_INT_STAT, 8'h00);
        pin(1'b1);
        wr(ADDR_INT_CTRL, 8'h00);
        meas(1'b1, 16'h1800);
        rd(ADDR_INT_STAT, 8'h00);
        wr(ADDR_INT_CTRL, 8'h22);
        meas(1'b0, 16'h3000);
        rd(ADDR_INT_STAT, 8'h00);
        meas(1'b0, 16'h3000);
        rd(ADDR_INT_STAT, 8'h01);
        wr(ADDR_INT_STAT, 8'h01);
        wr(ADDR_INT_CTRL, 8'h23);
        repeat (2) meas(1'b0, 16'h0005);
        rd(ADDR_INT_STAT, 8'h00);
        repeat (2) meas(1'b1, 16'h0005);
        rd(ADDR_INT_STAT, 8'h02);
        wr(ADDR_INT_STAT, 8'h02);
        wr(ADDR_INT_CTRL, 8'h00);
        ambSelfTimed = 1'b1;
        wrd(ADDR_INT_CTRL, 8'h04);
        meas(1'b1, 16'h1800);
        rd(ADDR_INT_STAT, 8'h00);
        ambSelfTimed = 1'b0;
        repeat (2) @(negedge mclk);
        meas(1'b1, 16'h1800);
        rd(ADDR_INT_STAT, 8'h04);
        end_sim();
    end
endmodule : result_threshold_interrupt_tb
`default_nettype wire
